// *** pgb_map.svh ***
// Register indices, field positions and reset values of the port 9 block
`ifndef PGB_MAP_SVH
`define PGB_MAP_SVH

// Register indices; the byte address is four times the index
`define PGB_DIR_INDEX      16'hFFC0
`define PGB_DATA_INDEX     16'hFFC1
`define PGB_INDEX_PAD      14'h0000

// Reset and fixed values
`define PGB_DIR_RST        8'h00
`define PGB_DIR_EXP_FORCE  8'h40
`define PGB_DATA_RST       8'h00
`define PGB_DATA_RO_MASK   8'h40
`define PGB_WO_READ        8'h00
`define PGB_EXP_RESET_OE   8'h78
`define PGB_ALT_MASK       8'hF8
`define PGB_RDATA_PAD      24'h000000
`define PGB_RDATA_RST      32'h00000000

// Pin positions
`define PGB_BIT_IRQ_C      0
`define PGB_BIT_IRQ_B      1
`define PGB_BIT_IRQ_A      2
`define PGB_BIT_RD         3
`define PGB_BIT_WR         4
`define PGB_BIT_AS         5
`define PGB_BIT_CLK        6
`define PGB_BIT_WAIT       7

`endif

// *** pgb_pad_model.sv ***
// Pad model for the port 9 pins: block drive against board drive
`default_nettype none

module pgb_pad_model (
  // Block drive
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board drive
  input  wire logic [7:0] ext_val,
  // Resolved pad level
  output logic [7:0]      pin_in
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // enable wins
  // Board always drives, so a floated pin reads the board level, never a stale one
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

`default_nettype wire

// *** pgb_pin_cell.sv ***
// One pad of the port: function select, direction and standby float
`default_nettype none

module pgb_pin_cell (
  // Port register view
  input  wire logic gpio_dir,
  input  wire logic gpio_val,
  // Alternate function
  input  wire logic alt_sel,
  input  wire logic alt_oe,
  input  wire logic alt_val,
  // Standby
  input  wire logic hw_standby,
  // Pad
  output logic      pin_out,
  output logic      pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Alternate function overrides both port registers
  assign pin_oe  = !hw_standby && (alt_sel ? alt_oe : gpio_dir);
  assign pin_out = alt_sel ? alt_val : gpio_val;

endmodule

`default_nettype wire

// *** pgb_pkg.sv ***
// Types shared by the port 9 block
`default_nettype none

package pgb_pkg;

  typedef enum logic {PGB_SINGLE_CHIP, PGB_EXPANDED} pgb_mode_t;

  typedef enum logic [1:0] {PGB_DP_IDLE, PGB_DP_WRITE, PGB_DP_READ} pgb_dphase_t;

  // Bus strobes and system clock level from the bus controller, active low strobes
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic as_n;
    logic clk;
  } pgb_bus_ctl_t;

  // Requests to the interrupt controller and converter, active low
  typedef struct packed {
    logic irq_a_n;
    logic irq_b_n;
    logic irq_c_n;
    logic trig_n;
  } pgb_req_t;

endpackage

`default_nettype wire

// *** pgb_port9.sv ***
// Port 9: eight pin GPIO with bus strobes, clock output, wait and request inputs
//
// Function
// - Direction bit one makes the pin an output, zero an input.
// - Direction register write-only; resets to bit 6 set expanded, zero single-chip.
// - Data read gives latch for output pins, live pin level for input pins.
// - Latch-or-pin read also holds for pins in alternate functions.
// - Data bit 6 read-only pin level; other bits read/write, reset zero.
// - Pins 0-2 feed interrupt requests; pin 0 also feeds conversion trigger.
// - Expanded mode: pins 3,4,5 drive read, write, address strobes regardless.
// - Single-chip mode: pins 3,4,5 are plain GPIO.
// - Expanded mode: pin 6 outputs the system clock.
// - Single-chip mode: pin 6 input when direction zero, clock out when one.
// - Expanded mode: pin 7 is the bus wait input regardless.
// - Single-chip mode: pin 7 is plain GPIO.
// - After reset in single-chip mode all pins are inputs.
// - After reset expanded: pins 0-2 inputs, pins 3-7 bus and clock functions.
// - Hardware standby floats every pin.
// - Software standby holds pins; strobes and clock output held high.
`include "pgb_map.svh"
`default_nettype none

module pgb_port9 (
  // Clock, reset, clock enable
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hce,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Operating mode and standby
  input  wire logic                  expanded_mode,
  input  wire logic                  hw_standby,
  input  wire logic                  sw_standby,
  // Bus controller
  input  wire pgb_pkg::pgb_bus_ctl_t bus_ctl,
  output logic                       wait_n,
  // Interrupt controller and converter
  output pgb_pkg::pgb_req_t          req,
  // Pads
  input  wire logic [7:0]            pin_in,
  output logic [7:0]                 pin_out,
  output logic [7:0]                 pin_oe
);

  import pgb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  pgb_mode_t   mode_q;
  pgb_mode_t   mode;
  logic        mode_ok_q;
  logic        is_exp;
  pgb_dphase_t dphase_q;
  logic        sel_dir_q;
  logic        sel_data_q;
  logic        addr_take;
  logic        hit_dir;
  logic        hit_data;
  logic        wr_dir;
  logic        wr_data;
  logic [7:0]  ddr_q;
  logic [7:0]  ddr_d;
  logic [7:0]  dr_q;
  logic [7:0]  dr_d;
  logic [7:0]  dir_eff_q;
  logic [7:0]  dir_eff_d;
  logic [7:0]  rd_bits;
  logic [31:0] hrdata_q;
  logic [7:0]  alt_sel;
  logic [7:0]  alt_oe;
  logic [7:0]  alt_val;

  ////////////////////////////////////////////////////////////////////////////
  // Mode capture
  // Mode strap is caught on the first enabled edge after release; until then
  // the strap is read live so the reset pin state already matches the mode.
  // mode latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ok_q <= 1'b0;
      mode_q    <= PGB_SINGLE_CHIP;
    end else if (hce && !mode_ok_q) begin
      mode_ok_q <= 1'b1;
      mode_q    <= expanded_mode ? PGB_EXPANDED : PGB_SINGLE_CHIP;
    end
  end

  assign mode   = mode_ok_q ? mode_q : (expanded_mode ? PGB_EXPANDED : PGB_SINGLE_CHIP);
  assign is_exp = (mode == PGB_EXPANDED);

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  // Zero wait states; a low clock enable stalls the bus instead of losing a transfer
  assign hreadyout = hce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addr_take = hsel && hready && htrans[1] && hce;
  assign hit_dir   = (haddr[31:2] == {`PGB_INDEX_PAD, `PGB_DIR_INDEX});
  assign hit_data  = (haddr[31:2] == {`PGB_INDEX_PAD, `PGB_DATA_INDEX});

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q   <= PGB_DP_IDLE;
      sel_dir_q  <= 1'b0;
      sel_data_q <= 1'b0;
    end else if (hce) begin
      if (addr_take) begin
        dphase_q   <= hwrite ? PGB_DP_WRITE : PGB_DP_READ;
        sel_dir_q  <= hit_dir;
        sel_data_q <= hit_data;
      end else begin
        dphase_q   <= PGB_DP_IDLE;
        sel_dir_q  <= 1'b0;
        sel_data_q <= 1'b0;
      end
    end
  end

  // CPU is asleep in software standby, so writes are dropped to keep pins frozen
  assign wr_dir  = (dphase_q == PGB_DP_WRITE) && sel_dir_q && !sw_standby;
  assign wr_data = (dphase_q == PGB_DP_WRITE) && sel_data_q && !sw_standby;

  ////////////////////////////////////////////////////////////////////////////
  // Port registers
  // data bit 6 not stored
  always_comb begin
    ddr_d = ddr_q;
    dr_d  = dr_q;
    if (wr_dir) begin
      ddr_d = hwdata[7:0];
    end
    if (wr_data) begin
      dr_d = hwdata[7:0] & ~`PGB_DATA_RO_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ddr_q <= `PGB_DIR_RST;
    end else if (hce) begin
      ddr_q <= ddr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dr_q <= `PGB_DATA_RST;
    end else if (hce) begin
      dr_q <= dr_d;
    end
  end

  // expanded bit 6 forced
  // Forcing through the mode keeps the expanded reset value without a mode-dependent reset
  assign dir_eff_q = ddr_q | (is_exp ? `PGB_DIR_EXP_FORCE : `PGB_DIR_RST);
  assign dir_eff_d = ddr_d | (is_exp ? `PGB_DIR_EXP_FORCE : `PGB_DIR_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Alternate functions
  // strobes override registers
  always_comb begin
    alt_sel = is_exp ? `PGB_ALT_MASK : `PGB_DIR_RST;
    alt_oe  = `PGB_ALT_MASK;
    alt_val = `PGB_DIR_RST;
    alt_sel[`PGB_BIT_CLK]  = is_exp || ddr_q[`PGB_BIT_CLK];
    alt_oe[`PGB_BIT_WAIT]  = 1'b0;
    alt_val[`PGB_BIT_RD]   = bus_ctl.rd_n | sw_standby;
    alt_val[`PGB_BIT_WR]   = bus_ctl.wr_n | sw_standby;
    alt_val[`PGB_BIT_AS]   = bus_ctl.as_n | sw_standby;
    alt_val[`PGB_BIT_CLK]  = bus_ctl.clk | sw_standby;
  end

  assign wait_n = is_exp ? pin_in[`PGB_BIT_WAIT] : 1'b1;

  // requests follow pins
  // Requests see the pad level even while the pin is an output; see the
  // direction-bit caution for software
  assign req = '{irq_a_n: pin_in[`PGB_BIT_IRQ_A],
                 irq_b_n: pin_in[`PGB_BIT_IRQ_B],
                 irq_c_n: pin_in[`PGB_BIT_IRQ_C],
                 trig_n:  pin_in[`PGB_BIT_IRQ_C]};

  ////////////////////////////////////////////////////////////////////////////
  // Per pin pads and read-back
  for (genvar i = 0; i < 8; i++) begin : g_pin
    // bit 6 reads pin
    // Next-state values give a read right after a write the new contents
    if (i == `PGB_BIT_CLK) begin : g_clk
      assign rd_bits[i] = pin_in[i];
    end else begin : g_gpio
      assign rd_bits[i] = dir_eff_d[i] ? dr_d[i] : pin_in[i];
    end

    pgb_pin_cell u_cell (
      .gpio_dir   (dir_eff_q[i]),
      .gpio_val   (dr_q[i]),
      .alt_sel    (alt_sel[i]),
      .alt_oe     (alt_oe[i]),
      .alt_val    (alt_val[i]),
      .hw_standby (hw_standby),
      .pin_out    (pin_out[i]),
      .pin_oe     (pin_oe[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data
  // Write-only direction and unmapped addresses read as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `PGB_RDATA_RST;
    end else if (addr_take && !hwrite) begin
      if (hit_data) begin
        hrdata_q <= {`PGB_RDATA_PAD, rd_bits};
      end else if (hit_dir) begin
        hrdata_q <= {`PGB_RDATA_PAD, `PGB_WO_READ};
      end else begin
        hrdata_q <= `PGB_RDATA_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_dir_write;
    (dphase_q == PGB_DP_WRITE) && sel_dir_q && hce && !sw_standby;
  endsequence

  sequence s_data_write;
    (dphase_q == PGB_DP_WRITE) && sel_data_q && hce && !sw_standby;
  endsequence

  sequence s_data_read;
    addr_take && hit_data && !hwrite && (dphase_q != PGB_DP_WRITE);
  endsequence

  sequence s_sw_hold;
    sw_standby && !hw_standby && hce;
  endsequence

  AST_DIR_TO_ENABLE: assert property (
    s_dir_write ##1 !hw_standby |-> pin_oe[2:0] == $past(hwdata[2:0]))
    else $error("direction write did not reach pin enables");

  AST_DIR_WRITE: assert property (
    s_dir_write ##0 !(addr_take && !hwrite) |=>
      ddr_q == $past(hwdata[7:0]) && hrdata == $past(hrdata))
    else $error("direction register did not take written value");

  AST_READ_MUX: assert property (
    s_data_read |=> hrdata[0] == ($past(ddr_q[0]) ? $past(dr_q[0]) : $past(pin_in[0])))
    else $error("data read of pin 0 chose wrong source");

  AST_ALT_READ: assert property (
    (s_data_read and is_exp) |=>
      hrdata[3] == ($past(ddr_q[3]) ? $past(dr_q[3]) : $past(pin_in[3])))
    else $error("data read of strobe pin chose wrong source");

  AST_BIT6_PIN: assert property (
    s_data_read |=> hrdata[6] == $past(pin_in[6]) && hrdata[31:8] == 24'h000000)
    else $error("data bit 6 did not reflect pin level");

  AST_BIT6_RO: assert property (
    s_data_write |=> dr_q[6] == 1'b0 && dr_q[5:0] == $past(hwdata[5:0]))
    else $error("data write stored wrong bits");

  AST_REQ_FOLLOW: assert property (
    req.irq_c_n == pin_in[0] && req.trig_n == pin_in[0] &&
    req.irq_b_n == pin_in[1] && req.irq_a_n == pin_in[2])
    else $error("request lines do not follow pins 0 to 2");

  AST_STROBES: assert property (
    is_exp && !hw_standby && !sw_standby |->
      pin_oe[5:3] == 3'h7 && pin_out[5:3] == {bus_ctl.as_n, bus_ctl.wr_n, bus_ctl.rd_n})
    else $error("expanded strobes not driven");

  AST_SC_GPIO: assert property (
    !is_exp && !hw_standby |-> pin_oe[5:3] == ddr_q[5:3] && pin_out[5:3] == dr_q[5:3])
    else $error("single-chip pins 3 to 5 not under port registers");

  AST_CLK_EXP: assert property (
    is_exp && !hw_standby |-> pin_oe[6] && pin_out[6] == (bus_ctl.clk | sw_standby))
    else $error("clock not output in expanded mode");

  AST_CLK_SC: assert property (
    !is_exp && !hw_standby |->
      pin_oe[6] == ddr_q[6] && (!ddr_q[6] || pin_out[6] == (bus_ctl.clk | sw_standby)))
    else $error("single-chip clock pin wrong");

  AST_WAIT: assert property (
    is_exp |-> !pin_oe[7] && wait_n == pin_in[7])
    else $error("wait pin not an input in expanded mode");

  AST_SC_P7: assert property (
    !is_exp && !hw_standby |-> pin_oe[7] == ddr_q[7] && pin_out[7] == dr_q[7] && wait_n)
    else $error("single-chip pin 7 not under port registers");

  AST_RESET_SC: assert property (
    $rose(mode_ok_q) && !is_exp && !hw_standby |-> pin_oe == `PGB_DIR_RST)
    else $error("single-chip pins not inputs after reset");

  AST_RESET_EXP: assert property (
    $rose(mode_ok_q) && is_exp && !hw_standby |-> pin_oe == `PGB_EXP_RESET_OE)
    else $error("expanded pins wrong after reset");

  AST_HW_STANDBY: assert property (
    hw_standby |-> pin_oe == `PGB_DIR_RST)
    else $error("pin driven in hardware standby");

  AST_SW_STANDBY: assert property (
    s_sw_hold ##1 s_sw_hold |-> $stable(pin_oe) && (!is_exp || pin_out[6:3] == 4'hF))
    else $error("pins not held in software standby");

  AST_MODE_HOLD: assert property (
    mode_ok_q ##1 mode_ok_q |-> $stable(mode) && mode == mode_q)
    else $error("mode changed after capture");

endmodule

`default_nettype wire

// *** pgb_testbench.sv ***
// Self-checking bench for the port 9 block
`include "pgb_map.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pgb_pkg::*;

  localparam logic [31:0] DIR_A  = {`PGB_INDEX_PAD, `PGB_DIR_INDEX, 2'b00};
  localparam logic [31:0] DATA_A = {`PGB_INDEX_PAD, `PGB_DATA_INDEX, 2'b00};
  localparam logic [31:0] NONE_A = DATA_A + 32'h00000004;

  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic [31:0]   haddr = 32'h00000000;
  logic [1:0]    htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic [31:0]   hwdata = 32'h00000000;
  logic          expanded_mode = 1'b0;
  logic          hw_standby = 1'b0;
  logic          sw_standby = 1'b0;
  pgb_bus_ctl_t  bus_ctl = 4'hF;
  logic [7:0]    ext_val = 8'hA5;
  logic          hreadyout, hresp, wait_n;
  logic [31:0]   hrdata, rd;
  pgb_req_t      req;
  logic [7:0]    pin_in, pin_out, pin_oe, dir, dat, ext, last;
  // Direction, data, board level, expected data read-back (clock level high)
  logic [31:0]   rows [4] = '{32'h00FFA5A5, 32'hFF3C007C, 32'h0F5AF0FA, 32'hF0870FCF};
  int            fail_count = 0;
  int            checked = 0;
  int            cycles = 0;

  always #12.5 hclk = ~hclk;

  pgb_port9 dut (.hclk(hclk), .hresetn(hresetn), .hce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .expanded_mode(expanded_mode),
    .hw_standby(hw_standby), .sw_standby(sw_standby), .bus_ctl(bus_ctl), .wait_n(wait_n),
    .req(req), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

  pgb_pad_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single AHB-Lite transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h00000000);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd, {24'h000000, e});
  endtask

  // Let the edge's updates land before looking at pins
  task automatic settle;
    @(negedge hclk);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h00000000);
    rdchk(DATA_A, 8'hA5);
    rdchk(DIR_A, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {dir, dat, ext, last} = rows[i];
      ext_val <= ext;
      wr(DIR_A, dir);
      wr(DATA_A, dat);
      settle();
      chk(32'(pin_oe), 32'(dir));
      chk(32'(pin_out & dir & 8'hBF), 32'(dat & dir & 8'hBF));
      if (dir[2:0] == 3'h0) begin
        chk(32'(req), {28'h0000000, ext[2], ext[1], ext[0], ext[0]});
      end
      rdchk(DATA_A, last);
    end
    // Unmapped write must not land anywhere
    wr(NONE_A, 8'hFF);
    rdchk(NONE_A, 8'h00);
    sw_standby <= 1'b1;
    wr(DATA_A, 8'h00);
    settle();
    chk(32'(pin_out & 8'hB0), 32'h00000080);
    @(posedge hclk);
    sw_standby <= 1'b0;
    rdchk(DATA_A, last);
    hw_standby <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h00000000);
    @(posedge hclk);
    hw_standby <= 1'b0;
    settle();
    chk(32'(pin_oe), 32'h000000F0);
    // Second reset into expanded operation, in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    expanded_mode <= 1'b1;
    bus_ctl <= 4'b0101;
    ext_val <= 8'h80;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    chk(32'(pin_oe), 32'h00000078);
    chk(32'(pin_out[6:3]), 32'h0000000A);
    chk(32'(wait_n), 32'h00000001);
    wr(DIR_A, 8'h07);
    wr(DATA_A, 8'hFF);
    settle();
    chk(32'(pin_oe), 32'h0000007F);
    chk(32'(pin_out[6:3]), 32'h0000000A);
    rdchk(DATA_A, 8'hD7);
    ext_val <= 8'h00;
    // Strap moves after capture; the latched mode must hold
    expanded_mode <= 1'b0;
    settle();
    chk(32'(wait_n), 32'h00000000);
    wr(DIR_A, 8'h00);
    settle();
    chk(32'(pin_oe), 32'h00000078);
    @(posedge hclk);
    sw_standby <= 1'b1;
    bus_ctl <= 4'h0;
    settle();
    chk(32'(pin_out[6:3]), 32'h0000000F);
    test_done();
  end
endmodule

`default_nettype wire
